// file: common/mode_ctrl_pkg.sv
package mode_ctrl_pkg;

  typedef enum logic [2:0] {
    MODE_STANDBY = 3'b001,
    MODE_WAKE    = 3'b010,
    MODE_SLEEP   = 3'b100
  } sys_mode_t;

  typedef enum logic [2:0] {
    RESTART_IDLE    = 3'b001,
    RESTART_STANDBY = 3'b010,
    RESTART_RESET   = 3'b100
  } restart_state_t;

endpackage

// file: common/mode_ctrl_regs.svh
`ifndef MODE_CTRL_REGS_SVH
`define MODE_CTRL_REGS_SVH

// Register offsets
`define SYSTEM_STATE_REG_ADDR       8'h14
`define SYSTEM_CONTROL_ONE_ADDR     8'h38
`define SYSTEM_CONTROL_TWO_ADDR     8'h39
`define INTERRUPT_WAKE_CONTROL_ADDR 8'h3A

// system_control_one fields
`define DOZE_RATE_MSB       7
`define DOZE_RATE_LSB       6
`define OUTPUT_RATE_MSB     4
`define OUTPUT_RATE_LSB     2
`define RANGE_MODE_MSB      1
`define RANGE_MODE_LSB      0
`define SYSTEM_CONTROL_ONE_MASK 8'hDF

// system_control_two fields
`define SELF_CHECK_BIT      7
`define SOFT_RESTART_BIT    6
`define AUTO_DOZE_BIT       1
`define LOW_POWER_BIT       0
`define SYSTEM_CONTROL_TWO_MASK 8'hC3

// interrupt_wake_control fields
`define FIFO_GATE_BIT       7
`define WAKE_SEL_MSB        6
`define WAKE_SEL_LSB        2
`define IRQ_POLARITY_BIT    1
`define IRQ_DRIVE_BIT       0

// system_state_reg fields
`define GATE_OVERFLOW_BIT   7

// Reset values
`define SYSTEM_CONTROL_ONE_RST     8'h00
`define SYSTEM_CONTROL_TWO_RST     8'h00
`define INTERRUPT_WAKE_CONTROL_RST 8'h00

// Sample periods in microseconds
`define PERIOD_400HZ_US  32'd2500
`define PERIOD_200HZ_US  32'd5000
`define PERIOD_100HZ_US  32'd10000
`define PERIOD_50HZ_US   32'd20000
`define PERIOD_25HZ_US   32'd40000
`define PERIOD_12HZ5_US  32'd80000
`define PERIOD_1HZ56_US  32'd640000

// Clock rate: 20 MHz, so 20 cycles per microsecond
`define CLK_CYCLES_PER_US 32'd20

`endif

// file: hw/system_mode_control.sv
`timescale 1ns/100ps
`include "mode_ctrl_regs.svh"

// What this block does
// - Rate codes 010..101 give 100, 50, 12.5, 1.563 Hz.
// - Range/mode field resets to 00; 00 is standby, nonzero is active.
// - Active range codes 01, 10, 11 give 2g, 4g, 8g full scale.
// - Self-check bit 7 of control two resets to 0; 1 enables self-test.
// - Self-test drives a deliberate output change for chain checks.
// - Low power bit 0 resets to 0 normal; 1 selects low power.
// - Auto-doze bit 1 resets to 0; 1 enables automatic sleep/wake.
// - Auto-doze: each sleep/wake change resets counters; flushes FIFO only with gate bit 0.
// - Sleep/wake changes leave functional block status untouched.
// - Restart bit 6 resets to 0 and is taken in standby or active.
// - Restart resets all registers and reloads nonvolatile defaults.
// - An active device drops to standby before restarting.
// - Restart also resets the serial interface logic.
// - Gate bit 0: FIFO flushed on every sleep/wake change.
// - Gate bit 1: FIFO kept, input blocked until host empties it.
// - A sample while gated and unemptied sets the overflow flag, held.
// - Overflow flag drops as soon as the FIFO is emptied.
// - Wake-select bits 6..2 let each function's interrupt end sleep.
// - Output rate field resets to 000, giving 400 Hz, 2.5 ms.
// - In sleep the doze rate replaces the system output rate.
// - Doze rate codes 00..11 give 50, 25, 12.5, 1.56 Hz.
module system_mode_control #(
  parameter int unsigned CYCLES_PER_US = `CLK_CYCLES_PER_US
) (
  // Clock and reset
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   RST_I,
  // Register access from the serial interface engine
  input  wire logic                   REG_WR_I,
  input  wire logic                   REG_RD_I,
  input  wire logic [7:0]             REG_ADDR_I,
  input  wire logic [7:0]             REG_WDATA_I,
  output logic      [7:0]             REG_RDATA_O,
  // Events from detection functions and inactivity timer
  input  wire logic                   SLEEP_REQ_I,
  input  wire logic [4:0]             WAKE_EVT_I,
  // FIFO handshake
  input  wire logic                   FIFO_EMPTY_I,
  output logic                        FIFO_FLUSH_O,
  output logic                        FIFO_BLOCK_O,
  output logic                        SAMPLE_TICK_O,
  // Operating state to the sensing path
  output mode_ctrl_pkg::sys_mode_t    MODE_O,
  output logic      [1:0]             RANGE_O,
  output logic                        LOW_POWER_O,
  output logic                        SELF_TEST_O,
  output logic                        IRQ_POLARITY_O,
  output logic                        IRQ_DRIVE_O,
  // Reset pulses to the rest of the device
  output logic                        COUNTER_RESET_O,
  output logic                        BLOCK_RESET_O,
  output logic                        NVM_RELOAD_O,
  output logic                        SERIAL_RESET_O
);
  import mode_ctrl_pkg::*;

  logic [7:0]     system_control_one;
  logic [7:0]     system_control_two;
  logic [7:0]     interrupt_wake_control;
  sys_mode_t      mode;
  restart_state_t restart;
  logic [31:0]    tick_count;
  logic           gate_overflow_flag;
  logic           restart_clear;
  logic           active_req;
  logic           doze_switch;
  logic [31:0]    period_cycles;

  logic [2:0] output_rate_select;
  logic [1:0] range_and_mode_select;
  logic [1:0] doze_rate_field;
  logic       self_check_enable;
  logic       auto_doze_enable;
  logic       low_power_select;
  logic       fifo_gate;
  logic [4:0] wake_select;

  assign output_rate_select    =
    system_control_one[`OUTPUT_RATE_MSB:`OUTPUT_RATE_LSB];
  assign range_and_mode_select =
    system_control_one[`RANGE_MODE_MSB:`RANGE_MODE_LSB];
  assign doze_rate_field       =
    system_control_one[`DOZE_RATE_MSB:`DOZE_RATE_LSB];
  assign self_check_enable     = system_control_two[`SELF_CHECK_BIT];
  assign auto_doze_enable      = system_control_two[`AUTO_DOZE_BIT];
  assign low_power_select      = system_control_two[`LOW_POWER_BIT];
  assign fifo_gate             = interrupt_wake_control[`FIFO_GATE_BIT];
  assign wake_select           =
    interrupt_wake_control[`WAKE_SEL_MSB:`WAKE_SEL_LSB];

  // Sample period in microseconds for the current rate settings
  function automatic logic [31:0] period_us(input logic [2:0] rate,
                                            input logic       dozing,
                                            input logic [1:0] doze);
    logic [31:0] p;
    p = `PERIOD_400HZ_US;
    if (dozing) begin
      case (doze)
        2'b00:   p = `PERIOD_50HZ_US;
        2'b01:   p = `PERIOD_25HZ_US;
        2'b10:   p = `PERIOD_12HZ5_US;
        default: p = `PERIOD_1HZ56_US;
      endcase
    end else begin
      case (rate)
        3'b000:  p = `PERIOD_400HZ_US;
        3'b001:  p = `PERIOD_200HZ_US;
        3'b010:  p = `PERIOD_100HZ_US;
        3'b011:  p = `PERIOD_50HZ_US;
        3'b100:  p = `PERIOD_12HZ5_US;
        3'b101:  p = `PERIOD_1HZ56_US;
        // Unassigned codes fall back to the fastest rate
        default: p = `PERIOD_400HZ_US;
      endcase
    end
    return p;
  endfunction

  // The sequencer forces standby while a restart is in flight
  assign active_req    = (range_and_mode_select != 2'b00) &&
                         (restart == RESTART_IDLE);
  assign restart_clear = (restart == RESTART_RESET);
  assign period_cycles = 32'(period_us(output_rate_select,
                                       mode == MODE_SLEEP,
                                       doze_rate_field) * CYCLES_PER_US);

  always_comb begin
    doze_switch = 1'b0;
    if (active_req && mode == MODE_WAKE) begin
      doze_switch = auto_doze_enable && SLEEP_REQ_I;
    end else if (active_req && mode == MODE_SLEEP) begin
      doze_switch = !auto_doze_enable ||
                    (|(WAKE_EVT_I & wake_select));
    end
  end

  // Configuration registers; the restart reset cycle reloads defaults
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || restart_clear) begin
      system_control_one     <= `SYSTEM_CONTROL_ONE_RST;
      system_control_two     <= `SYSTEM_CONTROL_TWO_RST;
      interrupt_wake_control <= `INTERRUPT_WAKE_CONTROL_RST;
    end else if (REG_WR_I && restart == RESTART_IDLE) begin
      if (REG_ADDR_I == `SYSTEM_CONTROL_ONE_ADDR) begin
        system_control_one <= REG_WDATA_I & `SYSTEM_CONTROL_ONE_MASK;
      end else if (REG_ADDR_I == `SYSTEM_CONTROL_TWO_ADDR) begin
        system_control_two <= REG_WDATA_I & `SYSTEM_CONTROL_TWO_MASK;
      end else if (REG_ADDR_I == `INTERRUPT_WAKE_CONTROL_ADDR) begin
        interrupt_wake_control <= REG_WDATA_I;
      end
    end
  end

  // Restart sequencer: standby first, then one reset cycle
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      restart <= RESTART_IDLE;
    end else begin
      case (restart)
        RESTART_IDLE: begin
          if (system_control_two[`SOFT_RESTART_BIT]) begin
            restart <= RESTART_STANDBY;
          end
        end
        RESTART_STANDBY: begin
          restart <= RESTART_RESET;
        end
        RESTART_RESET: begin
          restart <= RESTART_IDLE;
        end
        default: begin
          restart <= RESTART_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      BLOCK_RESET_O  <= 1'b0;
      NVM_RELOAD_O   <= 1'b0;
      SERIAL_RESET_O <= 1'b0;
    end else begin
      BLOCK_RESET_O  <= (restart == RESTART_STANDBY);
      NVM_RELOAD_O   <= (restart == RESTART_STANDBY);
      SERIAL_RESET_O <= (restart == RESTART_STANDBY);
    end
  end

  // System mode; leaving sleep/wake keeps every status flag as it was
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      mode <= MODE_STANDBY;
    end else begin
      case (mode)
        MODE_STANDBY: begin
          if (active_req) begin
            mode <= MODE_WAKE;
          end
        end
        MODE_WAKE: begin
          if (!active_req) begin
            mode <= MODE_STANDBY;
          end else if (doze_switch) begin
            mode <= MODE_SLEEP;
          end
        end
        MODE_SLEEP: begin
          if (!active_req) begin
            mode <= MODE_STANDBY;
          end else if (doze_switch) begin
            mode <= MODE_WAKE;
          end
        end
        default: begin
          mode <= MODE_STANDBY;
        end
      endcase
    end
  end

  assign MODE_O = mode;

  // Sample tick; nothing is sampled in standby
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || mode == MODE_STANDBY || doze_switch) begin
      tick_count    <= 32'h0000_0000;
      SAMPLE_TICK_O <= 1'b0;
    end else if (tick_count + 32'h0000_0001 >= period_cycles) begin
      tick_count    <= 32'h0000_0000;
      SAMPLE_TICK_O <= 1'b1;
    end else begin
      tick_count    <= tick_count + 32'h0000_0001;
      SAMPLE_TICK_O <= 1'b0;
    end
  end

  // Sleep/wake transition effects on FIFO and counters
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || restart_clear) begin
      FIFO_FLUSH_O    <= 1'b0;
      COUNTER_RESET_O <= 1'b0;
    end else begin
      FIFO_FLUSH_O    <= doze_switch && !fifo_gate;
      COUNTER_RESET_O <= doze_switch;
    end
  end

  // Gate holds FIFO contents until the host empties it
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || restart_clear) begin
      FIFO_BLOCK_O <= 1'b0;
    end else if (doze_switch && fifo_gate && !FIFO_EMPTY_I) begin
      FIFO_BLOCK_O <= 1'b1;
    end else if (FIFO_EMPTY_I) begin
      FIFO_BLOCK_O <= 1'b0;
    end
  end

  // Overflow flag: set on a blocked sample, cleared by emptying
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || restart_clear) begin
      gate_overflow_flag <= 1'b0;
    end else if (FIFO_EMPTY_I) begin
      gate_overflow_flag <= 1'b0;
    end else if (FIFO_BLOCK_O && SAMPLE_TICK_O) begin
      gate_overflow_flag <= 1'b1;
    end
  end

  // Settings handed to the sensing path
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I || restart_clear) begin
      RANGE_O        <= 2'h0;
      LOW_POWER_O    <= 1'b0;
      SELF_TEST_O    <= 1'b0;
      IRQ_POLARITY_O <= 1'b0;
      IRQ_DRIVE_O    <= 1'b0;
    end else begin
      RANGE_O        <= range_and_mode_select;
      LOW_POWER_O    <= low_power_select;
      SELF_TEST_O    <= self_check_enable;
      IRQ_POLARITY_O <= interrupt_wake_control[`IRQ_POLARITY_BIT];
      IRQ_DRIVE_O    <= interrupt_wake_control[`IRQ_DRIVE_BIT];
    end
  end

  // Read data, registered one cycle after the strobe
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      REG_RDATA_O <= 8'h00;
    end else if (REG_RD_I) begin
      if (REG_ADDR_I == `SYSTEM_STATE_REG_ADDR) begin
        REG_RDATA_O <= {gate_overflow_flag, 4'h0, mode};
      end else if (REG_ADDR_I == `SYSTEM_CONTROL_ONE_ADDR) begin
        REG_RDATA_O <= system_control_one;
      end else if (REG_ADDR_I == `SYSTEM_CONTROL_TWO_ADDR) begin
        REG_RDATA_O <= system_control_two;
      end else if (REG_ADDR_I == `INTERRUPT_WAKE_CONTROL_ADDR) begin
        REG_RDATA_O <= interrupt_wake_control;
      end else begin
        REG_RDATA_O <= 8'h00;
      end
    end
  end

endmodule

// file: test/fifo_model.sv
`timescale 1ns/100ps
module fifo_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Control from the block and the host
  input  wire logic flush_i,
  input  wire logic block_i,
  input  wire logic tick_i,
  input  wire logic drain_i,
  // Status back to the block
  output logic      empty_o
);
  logic [5:0] level;
  assign empty_o = (level == 6'h00);
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i || drain_i) begin
      level <= 6'h00;
    end else if (tick_i && !block_i && level != 6'h20) begin
      level <= level + 6'h01;
    end
  end
endmodule

// file: test/mode_ctrl_props.sv
`timescale 1ns/100ps
module mode_ctrl_props
  import mode_ctrl_pkg::*;
#(
  parameter int unsigned CYCLES_PER_US = 20
) (
  // Clock and reset
  input wire logic                     CLK_SYS_I,
  input wire logic                     RST_I,
  // Register port
  input wire logic                     REG_WR_I,
  input wire logic [7:0]               REG_ADDR_I,
  input wire logic [7:0]               REG_WDATA_I,
  // FIFO handshake
  input wire logic                     FIFO_EMPTY_I,
  input wire logic                     FIFO_FLUSH_O,
  input wire logic                     FIFO_BLOCK_O,
  // Operating state and pulses
  input wire mode_ctrl_pkg::sys_mode_t MODE_O,
  input wire logic [1:0]               RANGE_O,
  input wire logic                     LOW_POWER_O,
  input wire logic                     SELF_TEST_O,
  input wire logic                     COUNTER_RESET_O,
  input wire logic                     BLOCK_RESET_O,
  input wire logic                     NVM_RELOAD_O,
  input wire logic                     SERIAL_RESET_O
);
  import mode_ctrl_pkg::*;
  logic [2:0] busy;
  logic       rs;
  logic       wr1;
  // Writes landing inside the restart window are dropped, so skip them
  assign rs  = REG_WR_I && REG_ADDR_I == 8'h39 && REG_WDATA_I[6]
               && busy == 3'h0;
  assign wr1 = REG_WR_I && REG_ADDR_I == 8'h38 && busy == 3'h0;
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      busy <= 3'h0;
    end else if (rs) begin
      // Writes at the next three edges are refused or wiped by the restart reset
      busy <= 3'h3;
    end else if (busy != 3'h0) begin
      busy <= busy - 3'h1;
    end
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  range_follows_write_a: assert property (wr1 |-> ##2
    RANGE_O == $past(REG_WDATA_I[1:0], 2)) else $error("range copy wrong");
  standby_by_range_a: assert property (wr1 |-> ##2
    ((MODE_O == MODE_STANDBY) == ($past(REG_WDATA_I[1:0], 2) == 2'h0)))
    else $error("standby does not follow range");
  restart_sequence_a: assert property (rs |-> ##[1:3]
    (BLOCK_RESET_O && NVM_RELOAD_O && SERIAL_RESET_O
     && MODE_O == MODE_STANDBY)) else $error("restart pulses missing");
  restart_pulse_once_a: assert property (BLOCK_RESET_O |->
    busy != 3'h0 ##1 !BLOCK_RESET_O && !NVM_RELOAD_O)
    else $error("restart pulse stray or long");
  counter_on_doze_a: assert property ($past(MODE_O) != MODE_STANDBY
    && MODE_O != MODE_STANDBY && MODE_O != $past(MODE_O) |-> COUNTER_RESET_O)
    else $error("no counter reset on sleep wake change");
  no_counter_standby_a: assert property (MODE_O == MODE_STANDBY
    && $past(MODE_O) == MODE_STANDBY |-> !COUNTER_RESET_O)
    else $error("counter reset in standby");
  flush_or_gate_a: assert property ($past(MODE_O) == MODE_WAKE
    && MODE_O == MODE_SLEEP |-> FIFO_FLUSH_O || FIFO_BLOCK_O
    || $past(FIFO_EMPTY_I)) else $error("no flush or gate on sleep");
  block_release_a: assert property (FIFO_BLOCK_O && FIFO_EMPTY_I
    |=> !FIFO_BLOCK_O) else $error("gate held after fifo emptied");
  reset_defaults_a: assert property ($fell(RST_I) |->
    MODE_O == MODE_STANDBY && RANGE_O == 2'h0 && !LOW_POWER_O
    && !SELF_TEST_O) else $error("reset values wrong");
endmodule
bind system_mode_control mode_ctrl_props #(.CYCLES_PER_US(CYCLES_PER_US))
  u_props (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .REG_WR_I(REG_WR_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .FIFO_EMPTY_I(FIFO_EMPTY_I), .FIFO_FLUSH_O(FIFO_FLUSH_O),
  .FIFO_BLOCK_O(FIFO_BLOCK_O), .MODE_O(MODE_O), .RANGE_O(RANGE_O),
  .LOW_POWER_O(LOW_POWER_O), .SELF_TEST_O(SELF_TEST_O),
  .COUNTER_RESET_O(COUNTER_RESET_O), .BLOCK_RESET_O(BLOCK_RESET_O),
  .NVM_RELOAD_O(NVM_RELOAD_O), .SERIAL_RESET_O(SERIAL_RESET_O));

// file: test/tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module tb_top;
  import mode_ctrl_pkg::*;
  localparam int unsigned CPU = 1;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, slp = 1'b0;
  logic drain = 1'b0, empty, flush, block, tick, lp, st, irq_level_polarity, idrv;
  logic cr, br, nv, sr;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [4:0] wev = 5'h00;
  logic [1:0] range;
  sys_mode_t  mode;
  // Seed is 77225
  logic [31:0] seed = 32'h00012DA9;
  int num_errors = 0, checks = 0, n_cr = 0, n_fl = 0, n_rr = 0, n_tk = 0;
  always #25 clk = ~clk;
  system_mode_control #(.CYCLES_PER_US(CPU)) u_system_mode_control (
    .CLK_SYS_I(clk), .RST_I(rst), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .SLEEP_REQ_I(slp), .WAKE_EVT_I(wev), .FIFO_EMPTY_I(empty),
    .FIFO_FLUSH_O(flush), .FIFO_BLOCK_O(block), .SAMPLE_TICK_O(tick),
    .MODE_O(mode), .RANGE_O(range), .LOW_POWER_O(lp), .SELF_TEST_O(st),
    .IRQ_POLARITY_O(irq_level_polarity), .IRQ_DRIVE_O(idrv), .COUNTER_RESET_O(cr),
    .BLOCK_RESET_O(br), .NVM_RELOAD_O(nv), .SERIAL_RESET_O(sr));
  fifo_model u_fifo_model (.clk_i(clk), .rst_i(rst), .flush_i(flush),
    .block_i(block), .tick_i(tick), .drain_i(drain), .empty_o(empty));
  // Pulses launched at one edge are counted at the next, free of races
  always @(posedge clk) begin
    n_cr += cr;
    n_fl += flush;
    n_rr += br + nv + sr;
    n_tk += tick;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int exp_gap(input logic [2:0] r, input logic s);
    int ru[8] = '{2500, 5000, 10000, 20000, 80000, 640000, 2500, 2500};
    return (s ? 20000 : ru[r]) * CPU;
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    `CHK(rdata, e)
  endtask
  task automatic tick_gap(output int n);
    for (n = 0; n < 45000 && tick !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    for (n = 1; n < 45000 && tick !== 1'b1; n++) @(negedge clk);
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    // Longest clean run is about 75000 cycles
    repeat (90000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    int n, i, m;
    logic [7:0] d;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    `CHK(mode, MODE_STANDBY)
    rd_chk(8'h38, 8'h00);
    rd_chk(8'h39, 8'h00);
    rd_chk(8'h3A, 8'h00);
    rd_chk(8'h55, 8'h00);
    m = n_tk;
    step(3000);
    `CHK(n_tk, m)
    for (i = 0; i < 6; i++) begin
      seed = xs(seed);
      d = seed[7:0] & 8'hBF;
      wr_reg(8'h39, d);
      rd_chk(8'h39, d & 8'h83);
      `CHK({st, lp}, {d[7], d[0]})
      wr_reg(8'h3A, seed[15:8] & 8'h7F);
      rd_chk(8'h3A, seed[15:8] & 8'h7F);
      `CHK({irq_level_polarity, idrv}, seed[9:8])
    end
    wr_reg(8'h39, 8'h00);
    for (i = 0; i < 4; i++) begin
      wr_reg(8'h38, 8'h20 | i[7:0]);
      step(2);
      `CHK(range, i[1:0])
      `CHK(mode === MODE_STANDBY, i == 0)
      rd_chk(8'h38, i[7:0]);
    end
    tick_gap(n);
    `CHK(n, exp_gap(3'h0, 1'b0))
    wr_reg(8'h38, 8'h09);
    tick_gap(n);
    `CHK(n, exp_gap(3'h2, 1'b0))
    wr_reg(8'h38, 8'h01);
    wr_reg(8'h39, 8'h02);
    for (i = 0; i < 5; i++) begin
      wr_reg(8'h3A, 8'h04 << i);
      m = n_cr + n_fl;
      slp = 1'b1;
      step(1);
      slp = 1'b0;
      `CHK(mode, MODE_SLEEP)
      wev = ~(5'h01 << i);
      step(1);
      `CHK(mode, MODE_SLEEP)
      wev = 5'h01 << i;
      step(1);
      `CHK(mode, MODE_WAKE)
      wev = 5'h00;
      step(1);
      `CHK(n_cr + n_fl - m, 4)
    end
    slp = 1'b1;
    step(1);
    slp = 1'b0;
    tick_gap(n);
    `CHK(n, exp_gap(3'h0, 1'b1))
    wr_reg(8'h3A, 8'h90);
    m = n_fl;
    wev = 5'h04;
    step(1);
    wev = 5'h00;
    step(1);
    `CHK({mode, block, n_fl - m}, {MODE_WAKE, 1'b1, 32'h0})
    rd_chk(8'h14, 8'h02);
    tick_gap(n);
    rd_chk(8'h14, 8'h82);
    drain = 1'b1;
    step(1);
    drain = 1'b0;
    step(1);
    rd_chk(8'h14, 8'h02);
    `CHK(block, 1'b0)
    for (i = 0; i < 2; i++) begin
      m = n_rr;
      wr_reg(8'h39, 8'hC3);
      wr_reg(8'h38, 8'h03);
      step(4);
      `CHK({mode, n_rr - m}, {MODE_STANDBY, 32'h3})
      rd_chk(8'h39, 8'h00);
      rd_chk(8'h38, 8'h00);
      rd_chk(8'h3A, 8'h00);
    end
    wrap_up();
  end
endmodule
